// [hdl/fcr_pkg.sv]
// Constants and carrier types for the flash configuration register bank
package fcr_pkg;

	// Register map (byte addresses on the APB side)
	localparam int              FCR_ADDR_W          = 13;
	localparam logic [12:0]     FCR_POWER_CTRL_OFS  = 13'h104C;
	localparam logic [12:0]     FCR_LIMIT_RPT_OFS   = 13'h1050;

	// Field positions
	localparam int              FCR_OFF_BIT_POS     = 0;
	localparam int              FCR_DOZE_BIT_POS    = 1;
	localparam int              FCR_LIMIT_LSB       = 24;
	localparam int              FCR_LIMIT_W         = 7;
	localparam int              FCR_RSVD_ONE_POS    = 23;

	// Values after reset
	localparam logic            FCR_OFF_BIT_RST     = 1'b0;
	localparam logic            FCR_DOZE_BIT_RST    = 1'b0;
	localparam logic [6:0]      FCR_LIMIT_DEFAULT   = 7'h10;
	localparam logic [31:0]     FCR_RDATA_RST       = 32'h0000_0000;

	// One limit step covers 8 KB of program memory
	localparam int              FCR_LIMIT_GRAIN     = 13;

	// Wake time after flash was powered down
	localparam int              FCR_CLK_MHZ         = 40;
	localparam int              FCR_WAKE_NS         = 1000;
	localparam int              FCR_WAKE_CYC        =
		(FCR_WAKE_NS * FCR_CLK_MHZ + 999) / 1000;
	localparam int              FCR_WAKE_CNT_W      = $clog2(FCR_WAKE_CYC + 1);

	// Bus master request towards program flash, and its answer
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} fcr_mreq_t;

	typedef struct packed {
		logic        ready;
		logic        err;
		logic [31:0] rdata;
	} fcr_mrsp_t;

	// Answer of the flash array itself
	typedef struct packed {
		logic        ready;
		logic [31:0] rdata;
	} fcr_frsp_t;

	typedef enum logic [1:0] {PWR_ON, PWR_OFF, PWR_WAKE} fcr_pwr_t;
	typedef enum logic [1:0] {ACC_IDLE, ACC_FWD, ACC_RESP} fcr_acc_t;

endpackage

// [hdl/fcr_flash_config.sv]
// Flash power control and flash limit report registers with access gate
// Summary of operation
// - With the doze gate bit set, flash is powered down during doze once no access is being forwarded; with it clear, flash stays on.
// - Leaving doze with the doze gate bit set powers flash up again on its own.
// - Waking from doze with the doze gate bit set takes longer, covering flash power-up.
// - Any master access to flash while flash is disabled ends in a bus error.
// - Program memory off bit (bit 0) set gives bus errors on flash access and a low power flash; clear keeps flash on outside gated doze.
// - Flash stays in low power for as long as the program memory off bit stays set.
// - The limit report holds the read-only 7-bit program memory limit in bits 30 to 24.
// - Bit 23 of the limit report always reads one and ignores writes.
// - All other reserved bits of both registers read zero and ignore writes.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module fcr_flash_config
	import fcr_pkg::*;
#(
	parameter logic [6:0] LIMIT    = FCR_LIMIT_DEFAULT,
	parameter int         WAKE_CYC = FCR_WAKE_CYC
) (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [FCR_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Power mode controller
	input  wire logic                  doze_mode,
	output logic                       flash_wake_busy,
	// Bus masters towards program flash
	input  wire fcr_mreq_t             mreq,
	output fcr_mrsp_t                  mrsp,
	// Program flash array
	output fcr_mreq_t                  freq,
	input  wire fcr_frsp_t             frsp,
	output logic                       flash_low_power
);

	localparam int CNT_W = $clog2(WAKE_CYC + 1);

	if (WAKE_CYC < 1) begin : g_chk_wake
		$error("WAKE_CYC must be at least one cycle");
	end
	if (LIMIT == 7'h00) begin : g_chk_limit
		$error("LIMIT must describe at least one 8 KB block");
	end

	function automatic logic fcr_hit(
		input logic [FCR_ADDR_W-1:0] addr,
		input logic [12:0]           ofs
	);
		fcr_hit = (addr == ofs);
	endfunction

	// Register state
	logic                  doze_gate_bit_ff;
	logic                  program_memory_off_bit_ff;
	logic [31:0]           prdata_ff;
	fcr_pwr_t              pwr_ff;
	fcr_pwr_t              nxt_pwr;
	logic [CNT_W-1:0]      wake_cnt_ff;
	logic [CNT_W-1:0]      nxt_wake_cnt;
	logic                  low_power_ff;
	logic                  wake_busy_ff;
	fcr_acc_t              acc_ff;
	fcr_acc_t              nxt_acc;
	fcr_mrsp_t             mrsp_ff;
	fcr_mrsp_t             nxt_mrsp;
	fcr_mreq_t             freq_ff;
	fcr_mreq_t             nxt_freq;

	// APB decode
	wire logic             hit_power  = fcr_hit(paddr, FCR_POWER_CTRL_OFS);
	wire logic             hit_limit  = fcr_hit(paddr, FCR_LIMIT_RPT_OFS);
	wire logic             mapped     = hit_power | hit_limit;
	wire logic             setup_ph   = psel & ~penable;
	wire logic             access_ph  = psel & penable;
	wire logic             wr_power   = access_ph & pwrite & hit_power &
		pstrb[0];

	// Read views of both registers
	wire logic [31:0]      power_view;
	wire logic [31:0]      limit_view;
	wire logic [31:0]      rd_mux;

	assign power_view = {30'h0000_0000, doze_gate_bit_ff,
		program_memory_off_bit_ff};
	assign limit_view = {1'b0, LIMIT, 1'b1, 23'h00_0000};
	assign rd_mux     = hit_power ? power_view :
		(hit_limit ? limit_view : 32'h0000_0000);

	// Zero wait states; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = access_ph & ~mapped;
	assign prdata  = prdata_ff;

	// Read data is captured in the setup phase so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= FCR_RDATA_RST;
		end else if (setup_ph) begin
			prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
		end
	end

	// Only the two control bits are writable; other lanes are ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			doze_gate_bit_ff          <= FCR_DOZE_BIT_RST;
			program_memory_off_bit_ff <= FCR_OFF_BIT_RST;
		end else if (wr_power) begin
			doze_gate_bit_ff          <= pwdata[FCR_DOZE_BIT_POS];
			program_memory_off_bit_ff <= pwdata[FCR_OFF_BIT_POS];
		end
	end

	// Flash power control
	wire logic doze_off  = doze_mode & doze_gate_bit_ff;
	wire logic off_req   = program_memory_off_bit_ff | doze_off;
	wire logic acc_quiet = (acc_ff != ACC_FWD);
	wire logic wake_done = (wake_cnt_ff == '0);

	// A pending flash access is allowed to finish before power drops,
	// trading a few cycles of delay for never cutting a live transfer.
	always_comb begin
		nxt_pwr      = pwr_ff;
		nxt_wake_cnt = wake_cnt_ff;
		case (pwr_ff)
			PWR_ON: begin
				if (off_req && acc_quiet) begin
					nxt_pwr = PWR_OFF;
				end
			end
			PWR_OFF: begin
				if (!off_req) begin
					nxt_pwr      = PWR_WAKE;
					nxt_wake_cnt = CNT_W'(WAKE_CYC - 1);
				end
			end
			PWR_WAKE: begin
				if (off_req) begin
					nxt_pwr = PWR_OFF;
				end else if (wake_done) begin
					nxt_pwr = PWR_ON;
				end else begin
					nxt_wake_cnt = wake_cnt_ff - CNT_W'(1);
				end
			end
			default: begin
				nxt_pwr = PWR_OFF;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_ff       <= PWR_ON;
			wake_cnt_ff  <= '0;
			low_power_ff <= 1'b0;
			wake_busy_ff <= 1'b0;
		end else begin
			pwr_ff       <= nxt_pwr;
			wake_cnt_ff  <= nxt_wake_cnt;
			low_power_ff <= (nxt_pwr == PWR_OFF);
			wake_busy_ff <= (nxt_pwr == PWR_WAKE);
		end
	end

	assign flash_low_power = low_power_ff;
	assign flash_wake_busy = wake_busy_ff;

	// Flash access gate
	wire logic [31:0] limit_addr;
	wire logic        beyond;
	wire logic        gate_open;
	wire logic        take;

	assign limit_addr = {12'h000, LIMIT, 13'h0000};
	assign beyond     = (mreq.addr >= limit_addr);
	assign gate_open  = (pwr_ff == PWR_ON) & ~off_req;
	assign take       = mreq.valid & (acc_ff == ACC_IDLE);

	// RESP lasts one cycle so the request that was just answered
	// is not taken a second time while the master drops it.
	always_comb begin
		nxt_acc  = acc_ff;
		nxt_mrsp = '0;
		nxt_freq = freq_ff;
		case (acc_ff)
			ACC_IDLE: begin
				if (take && (!gate_open || beyond)) begin
					nxt_mrsp.ready = 1'b1;
					nxt_mrsp.err   = 1'b1;
					nxt_acc        = ACC_RESP;
				end else if (take) begin
					nxt_freq       = mreq;
					nxt_acc        = ACC_FWD;
				end
			end
			ACC_FWD: begin
				if (frsp.ready) begin
					nxt_freq       = '0;
					nxt_mrsp.ready = 1'b1;
					nxt_mrsp.rdata = freq_ff.write ? 32'h0000_0000 :
						frsp.rdata;
					nxt_acc        = ACC_RESP;
				end
			end
			ACC_RESP: begin
				nxt_acc = ACC_IDLE;
			end
			default: begin
				nxt_acc  = ACC_IDLE;
				nxt_freq = '0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_ff  <= ACC_IDLE;
			mrsp_ff <= '0;
			freq_ff <= '0;
		end else begin
			acc_ff  <= nxt_acc;
			mrsp_ff <= nxt_mrsp;
			freq_ff <= nxt_freq;
		end
	end

	assign mrsp = mrsp_ff;
	assign freq = freq_ff;

endmodule // fcr_flash_config

// [verification/fcr_flash_config_checker.sv]
// Port assertions for the flash configuration register bank
`timescale 1ns/1ps
module fcr_flash_config_checker
	import fcr_pkg::*;
#(
	parameter logic [6:0] LIMIT    = FCR_LIMIT_DEFAULT,
	parameter int         WAKE_CYC = FCR_WAKE_CYC
) (
	// Clock, reset and APB
	input wire logic                  pclk, presetn, psel, penable, pwrite,
	input wire logic [FCR_ADDR_W-1:0] paddr,
	input wire logic [31:0]           prdata,
	input wire logic                  pslverr,
	// Flash side
	input wire logic                  flash_wake_busy, flash_low_power,
	input wire fcr_mreq_t             mreq, freq,
	input wire fcr_mrsp_t             mrsp,
	input wire fcr_frsp_t             frsp
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire idle_req = mreq.valid && !mrsp.ready && !freq.valid;
	int  wake_ff;
	int  nxt_wake;
	assign nxt_wake = flash_wake_busy ? wake_ff + 1 : 0;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) wake_ff <= 0;
		else wake_ff <= nxt_wake;
	a_apb_decode: assert property (acc |-> pslverr ==
		(paddr != FCR_POWER_CTRL_OFS && paddr != FCR_LIMIT_RPT_OFS))
		else $error("bad decode");
	a_limit_read: assert property (
		acc && !pwrite && paddr == FCR_LIMIT_RPT_OFS
		|-> prdata == {1'b0, LIMIT, 1'b1, 23'h0}) else $error("bad limit");
	a_off_refuse: assert property (
		idle_req && (flash_low_power || flash_wake_busy)
		|=> mrsp.ready && mrsp.err) else $error("no bus error");
	a_range_refuse: assert property (
		idle_req && mreq.addr >= {LIMIT, 13'h0} |=> mrsp.err)
		else $error("no range error");
	a_lp_quiet: assert property (flash_low_power |-> !freq.valid)
		else $error("access while off");
	a_fwd_answer: assert property (freq.valid && frsp.ready |=> mrsp.ready
		&& !mrsp.err && mrsp.rdata == $past(frsp.rdata)) else $error("bad answer");
	a_err_nodata: assert property (mrsp.err |-> mrsp.ready && mrsp.rdata == 0)
		else $error("bad error answer");
	a_wake_len: assert property (
		$fell(flash_wake_busy) && !flash_low_power |-> wake_ff == WAKE_CYC)
		else $error("bad wake length");
endmodule // fcr_flash_config_checker

bind fcr_flash_config fcr_flash_config_checker
	#(.LIMIT(LIMIT), .WAKE_CYC(WAKE_CYC)) chk (.*);

// [verification/fcr_flash_model.sv]
// Program flash array stand-in answering forwarded requests
`timescale 1ns/1ps
module fcr_flash_model
	import fcr_pkg::*;
(
	// Clock and request
	input  wire logic       pclk,
	input  wire logic [3:0] wait_cyc,
	input  wire fcr_mreq_t  freq,
	// Answer
	output fcr_frsp_t       frsp
);
	logic [3:0] cnt_ff;
	wire        fire = freq.valid && !frsp.ready && cnt_ff >= wait_cyc;
	initial begin
		frsp = '0;
		cnt_ff = '0;
	end
	// Data toggles between answers so a stale copy never passes
	always @(posedge pclk) begin
		cnt_ff <= (freq.valid && !frsp.ready) ? cnt_ff + 4'h1 : 4'h0;
		frsp.ready <= fire;
		frsp.rdata <= fire ? freq.addr ^ 32'h5A5A_0000 : ~frsp.rdata;
	end
endmodule // fcr_flash_model

// [verification/fcr_flash_config_bench.sv]
// Self-checking bench for the flash configuration register bank
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module fcr_flash_config_bench
	import fcr_pkg::*;
;
	localparam int          WK  = 3;
	localparam logic [6:0]  LIM = 7'h10;
	localparam logic [12:0] PC  = FCR_POWER_CTRL_OFS;
	localparam logic [12:0] LR  = FCR_LIMIT_RPT_OFS;
	logic        pclk, presetn, psel, penable, pwrite, doze_mode, er;
	logic        pready, pslverr, flash_wake_busy, flash_low_power;
	logic [12:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb, wait_cyc;
	fcr_mreq_t   mreq, freq;
	fcr_mrsp_t   mrsp;
	fcr_frsp_t   frsp;
	int          fails = 0, tests_run = 0;

	fcr_flash_config #(.LIMIT(LIM), .WAKE_CYC(WK)) uut (.*);
	fcr_flash_model flash (.pclk(pclk), .wait_cyc(wait_cyc), .freq(freq),
		.frsp(frsp));

	task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic macc(input logic [31:0] a, input logic e);
		int n;
		n = 0;
		mreq <= '{1'b1, 1'b0, a, 32'h0};
		do @(posedge pclk); while (mrsp.ready !== 1'b1 && ++n < 40);
		mreq <= '0;
		`CHK(mrsp.err, e)
		`CHK(mrsp.rdata, e ? 32'h0 : a ^ 32'h5A5A_0000)
		@(posedge pclk);
	endtask
	// Waits for the wake phase to start, then counts how long it stands,
	// so the check does not depend on how far the caller is from the edge
	task automatic awake();
		int n;
		n = 0;
		while (flash_wake_busy !== 1'b1 && n < 10) begin
			@(posedge pclk);
			n++;
		end
		`CHK(flash_wake_busy, 1'b1)
		n = 0;
		while (flash_wake_busy === 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		`CHK(n, WK)
	endtask
	task automatic results();
		$display("Checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// Whole run needs under a hundred cycles
	initial begin
		#50000;
		fails++;
		results();
	end
	initial begin
		{presetn, psel, penable, pwrite, doze_mode} = '0;
		{paddr, pwdata, mreq, wait_cyc} = '0;
		pstrb = 4'hF;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, PC, 32'h0); `CHK(rd, 32'h0)
		apb(1'b1, LR, 32'hFFFF_FFFF);
		apb(1'b0, LR, 32'h0); `CHK(rd, {1'b0, LIM, 1'b1, 23'h0})
		apb(1'b0, 13'h1054, 32'h0); `CHK(er, 1'b1)
		macc(32'h0001_FFFC, 1'b0);
		macc({12'h0, LIM, 13'h0}, 1'b1);
		apb(1'b1, PC, 32'hFFFF_FFFF);
		apb(1'b0, PC, 32'h0); `CHK(rd, 32'h3)
		`CHK(flash_low_power, 1'b1)
		macc(32'h0, 1'b1);
		apb(1'b1, PC, 32'h0);
		awake();
		macc(32'h100, 1'b0);
		apb(1'b1, PC, 32'h2);
		doze_mode <= 1'b1;
		repeat (3) @(posedge pclk);
		`CHK(flash_low_power, 1'b1)
		macc(32'h200, 1'b1);
		doze_mode <= 1'b0;
		awake();
		macc(32'h300, 1'b0);
		apb(1'b1, PC, 32'h0);
		doze_mode <= 1'b1;
		wait_cyc <= 4'h4;
		repeat (3) @(posedge pclk);
		`CHK(flash_low_power, 1'b0)
		macc(32'h400, 1'b0);
		results();
	end
endmodule // fcr_flash_config_bench
